//--- sfx_pkg.sv
// Shared constants and types for the serial flash front end
package sfx_pkg;

	// Address and frame widths, in bits on the wire
	localparam int        ADDR_W    = 24;
	localparam logic [4:0] BITS_CMD  = 5'h08;
	localparam logic [4:0] BITS_ADDR = 5'h18;
	localparam logic [4:0] STEP_ONE  = 5'h01;
	localparam logic [4:0] STEP_QUAD = 5'h04;

	// Instruction codes
	localparam logic [7:0] OP_ENTER_QUAD = 8'h35;
	localparam logic [7:0] OP_EXIT_QUAD  = 8'hF5;
	localparam logic [7:0] OP_RST_EN     = 8'h66;
	localparam logic [7:0] OP_RST        = 8'h99;
	localparam logic [7:0] OP_READ       = 8'h03;
	localparam logic [7:0] OP_FREAD      = 8'h0B;
	localparam logic [7:0] OP_FREAD_DTR  = 8'h0D;
	localparam logic [7:0] OP_PROG       = 8'h02;
	localparam logic [7:0] OP_SER_A      = 8'hD7;
	localparam logic [7:0] OP_SER_B      = 8'h20;
	localparam logic [7:0] OP_BER32      = 8'h52;
	localparam logic [7:0] OP_BER64      = 8'hD8;
	localparam logic [7:0] OP_CER_A      = 8'hC7;
	localparam logic [7:0] OP_CER_B      = 8'h60;
	localparam logic [7:0] OP_SET_RDPAR  = 8'hC0;

	// Dummy clocks; the double-rate read needs half of the single-rate count
	localparam logic [3:0] DUMMY_SDR  = 4'h8;
	localparam logic [3:0] DUMMY_DDR  = DUMMY_SDR >> 1;
	localparam logic [3:0] DUMMY_NONE = 4'h0;

	// Erase granularity and alignment masks
	typedef enum logic [1:0] {
		ER_SECTOR = 2'h0,
		ER_BLK32  = 2'h1,
		ER_BLK64  = 2'h2,
		ER_CHIP   = 2'h3
	} sfx_erase_t;
	localparam logic [23:0] MASK_4K  = 24'h000FFF;
	localparam logic [23:0] MASK_32K = 24'h007FFF;
	localparam logic [23:0] MASK_64K = 24'h00FFFF;

	// Read settings byte layout and reset values
	localparam int         RP_BL_LSB   = 0;
	localparam int         RP_WRAP_BIT = 2;
	localparam int         RP_DRV_LSB  = 5;
	localparam logic [2:0] DRV_COUNT   = 3'h6;
	localparam logic [1:0] RP_BL_RST   = 2'h0;
	localparam logic       RP_WRAP_RST = 1'h0;
	localparam logic [2:0] RP_DRV_RST  = 3'h0;
	localparam logic [23:0] WRAP_BASE  = 24'h000008;

	// Pin drive patterns
	localparam logic [3:0] OE_SINGLE = 4'h2;
	localparam logic [3:0] OE_QUAD   = 4'hF;

	// Frame sequencer states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_CMD    = 3'h1,
		ST_ADDR   = 3'h2,
		ST_DUMMY  = 3'h3,
		ST_WDATA  = 3'h4,
		ST_RDATA  = 3'h5,
		ST_IGNORE = 3'h6
	} sfx_state_t;

endpackage

//--- sfx_pin_sync.sv
// Three-stage pin synchroniser with agreed-level edge pulses
`timescale 1ns/1ps
module sfx_pin_sync #(
	parameter int W = 6
) (
	// Clock and reset
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst_n,
	// Raw pins
	input  wire logic [W-1:0] i_pins,
	// Filtered level and edges
	output logic      [W-1:0] o_level,
	output logic      [W-1:0] o_rise,
	output logic      [W-1:0] o_fall
);

	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic lvl_q;
			logic rise_q;
			logic fall_q;
			// Only the second and third stages vote; the first stays private
			always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					s1_q   <= 1'h0;
					s2_q   <= 1'h0;
					s3_q   <= 1'h0;
					lvl_q  <= 1'h0;
					rise_q <= 1'h0;
					fall_q <= 1'h0;
				end else begin
					s1_q   <= i_pins[g];
					s2_q   <= s1_q;
					s3_q   <= s2_q;
					lvl_q  <= (s2_q == s3_q) ? s3_q : lvl_q;
					rise_q <= s2_q & s3_q & ~lvl_q;
					fall_q <= ~s2_q & ~s3_q & lvl_q;
				end
			end
			assign o_level[g] = lvl_q;
			assign o_rise[g]  = rise_q;
			assign o_fall[g]  = fall_q;
		end
	endgenerate

endmodule

//--- sfx_front_end.sv
// Serial flash interface front end: single and quad command modes, SDR and DTR
`timescale 1ns/1ps
module sfx_front_end
	import sfx_pkg::*;
(
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	// Flash pins
	input  wire logic        i_cs_n,
	input  wire logic        i_sck,
	input  wire logic [3:0]  i_io,
	output logic      [3:0]  o_io,
	output logic      [3:0]  o_io_oe,
	// Configuration and status
	input  wire logic        i_quad_enable,
	output logic             o_wp_protect,
	output logic             o_quad_mode,
	output logic             o_cmd_valid,
	output logic      [7:0]  o_cmd,
	// Array read path
	output logic             o_rd_req,
	output logic      [23:0] o_rd_addr,
	input  wire logic [7:0]  i_rd_data,
	// Array program path
	output logic             o_prog_valid,
	output logic      [23:0] o_prog_addr,
	output logic      [7:0]  o_prog_data,
	// Array erase path
	output logic             o_erase_valid,
	output logic      [1:0]  o_erase_kind,
	output logic      [23:0] o_erase_addr,
	// Read settings
	output logic      [1:0]  o_burst_len,
	output logic             o_wrap_en,
	output logic      [2:0]  o_drive_str
);

	logic [5:0]  lvl;
	logic [5:0]  rise;
	logic [5:0]  fall;
	sfx_state_t  st_q;
	sfx_state_t  st_d;
	logic        armed_q;
	logic        qpi_q;
	logic        dtr_q;
	logic        rst_en_q;
	logic        is_read_q;
	logic [7:0]  op_q;
	logic [7:0]  sh_q;
	logic [4:0]  bcnt_q;
	logic [23:0] addr_q;
	logic [3:0]  dneed_q;
	logic [3:0]  dcnt_q;
	logic [7:0]  osh_q;
	logic [2:0]  obcnt_q;
	logic [15:0] page_q;
	logic [7:0]  poff_q;
	logic        er_pend_q;
	logic [1:0]  er_kind_q;
	logic [23:0] er_addr_q;
	logic [1:0]  bl_q;
	logic        wrap_q;
	logic [2:0]  drv_q;

	// All pins come from the host's domain
	sfx_pin_sync #(
		.W (6)
	) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_pins    ({i_io, i_sck, i_cs_n}),
		.o_level   (lvl),
		.o_rise    (rise),
		.o_fall    (fall)
	);

	// Pin views; a frame only counts once chip select was seen high
	wire        cs_high = lvl[0];
	wire        cs_rise = rise[0];
	wire        sck_r   = rise[1];
	wire        sck_f   = fall[1];
	wire [3:0]  io_lvl  = lvl[5:2];
	wire        sel     = armed_q & ~cs_high;

	// Inbound sampling: rising edges, plus falling edges of a DTR address
	wire        cmd_ph  = (st_q == ST_IDLE) | (st_q == ST_CMD);
	wire        in_st   = cmd_ph | (st_q == ST_ADDR) | (st_q == ST_WDATA);
	wire        ddr_f   = sck_f & dtr_q & (st_q == ST_ADDR) & (bcnt_q != 5'h00);
	wire        in_edge = sel & in_st & (sck_r | ddr_f);
	wire [4:0]  step    = qpi_q ? STEP_QUAD : STEP_ONE;
	wire [4:0]  bsum    = bcnt_q + step;
	wire [7:0]  sh_nx   = qpi_q ? {sh_q[3:0], io_lvl} : {sh_q[6:0], io_lvl[0]};
	wire [23:0] addr_nx = qpi_q ? {addr_q[19:0], io_lvl} : {addr_q[22:0], io_lvl[0]};
	wire        cmd_done  = cmd_ph & in_edge & (bsum == BITS_CMD);
	wire        addr_done = (st_q == ST_ADDR) & in_edge & (bsum == BITS_ADDR);
	wire        wr_done   = (st_q == ST_WDATA) & in_edge & (bsum == BITS_CMD);
	wire        dum_done  = sel & (st_q == ST_DUMMY) & sck_r & ((dcnt_q + 4'h1) == dneed_q);

	// Opcode classes decided from the byte as it completes
	wire        op_rd    = (sh_nx == OP_READ) | (sh_nx == OP_FREAD) | (sh_nx == OP_FREAD_DTR);
	wire        op_sec   = (sh_nx == OP_SER_A) | (sh_nx == OP_SER_B);
	wire        op_erase = op_sec | (sh_nx == OP_BER32) | (sh_nx == OP_BER64);
	wire        op_chip  = (sh_nx == OP_CER_A) | (sh_nx == OP_CER_B);
	wire        op_addr  = op_rd | op_erase | (sh_nx == OP_PROG);
	wire        sw_rst   = cmd_done & rst_en_q & (sh_nx == OP_RST);

	// Outbound shifting: falling edges, plus rising edges in DTR reads
	wire        out_edge = sel & (st_q == ST_RDATA) & (sck_f | (dtr_q & sck_r));
	wire        ostart   = out_edge & (obcnt_q == 3'h0);
	wire [7:0]  obyte    = ostart ? i_rd_data : osh_q;
	wire [2:0]  ostep    = qpi_q ? 3'h4 : 3'h1;
	wire        enter_rd = (st_q != ST_RDATA) & (st_d == ST_RDATA);

	// Wrapped burst address step within an aligned window
	wire [23:0] wmask    = (WRAP_BASE << bl_q) - 24'h000001;
	wire [23:0] inc_addr = addr_q + 24'h000001;
	wire [23:0] wrap_nx  = wrap_q ? ((addr_q & ~wmask) | (inc_addr & wmask)) : inc_addr;
	wire [23:0] rd_nx    = enter_rd ? ((st_q == ST_ADDR) ? addr_nx : addr_q) : wrap_nx;

	// Erase alignment per granularity
	wire [23:0] er_mask  = op_q == OP_BER64 ? MASK_64K : (op_q == OP_BER32 ? MASK_32K : MASK_4K);

	// Frame sequencer
	always_comb begin
		st_d = st_q;
		if (!sel) begin
			st_d = ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE, ST_CMD: begin
					if (cmd_done) begin
						st_d = op_addr ? ST_ADDR : ((sh_nx == OP_SET_RDPAR) ? ST_WDATA : ST_IGNORE);
					end else begin
						st_d = ST_CMD;
					end
				end
				ST_ADDR: begin
					if (addr_done && is_read_q) begin
						st_d = (dneed_q != DUMMY_NONE) ? ST_DUMMY : ST_RDATA;
					end else if (addr_done) begin
						st_d = (op_q == OP_PROG) ? ST_WDATA : ST_IGNORE;
					end
				end
				ST_DUMMY: begin
					if (dum_done) begin
						st_d = ST_RDATA;
					end
				end
				ST_WDATA: begin
					if (wr_done && op_q != OP_PROG) begin
						st_d = ST_IGNORE;
					end
				end
				ST_RDATA, ST_IGNORE: st_d = st_q;
				default: st_d = ST_IDLE;
			endcase
		end
	end

	// State and arming; a reset while chip select is low must not start a frame
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q    <= ST_IDLE;
			armed_q <= 1'h0;
		end else begin
			st_q    <= st_d;
			armed_q <= armed_q | cs_high;
		end
	end

	// Inbound shifter and bit counter
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh_q   <= 8'h00;
			bcnt_q <= 5'h00;
		end else if (!sel) begin
			bcnt_q <= 5'h00;
		end else if (in_edge) begin
			sh_q   <= sh_nx;
			bcnt_q <= (cmd_done | addr_done | wr_done) ? 5'h00 : bsum;
		end
	end

	// Instruction capture and mode control
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			qpi_q     <= 1'h0;
			rst_en_q  <= 1'h0;
			op_q      <= 8'h00;
			is_read_q <= 1'h0;
			dtr_q     <= 1'h0;
			dneed_q   <= DUMMY_NONE;
		end else if (!sel) begin
			dtr_q <= 1'h0;
		end else if (cmd_done) begin
			op_q      <= sh_nx;
			is_read_q <= op_rd;
			rst_en_q  <= (sh_nx == OP_RST_EN);
			dtr_q     <= (sh_nx == OP_FREAD_DTR);
			dneed_q   <= (sh_nx == OP_FREAD_DTR) ? DUMMY_DDR : ((sh_nx == OP_FREAD) ? DUMMY_SDR : DUMMY_NONE);
			if (sh_nx == OP_ENTER_QUAD) begin
				qpi_q <= 1'h1;
			end else if (sh_nx == OP_EXIT_QUAD || sw_rst) begin
				qpi_q <= 1'h0;
			end
		end
	end

	// Address shifter doubles as the read pointer
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_q <= 24'h000000;
		end else if (in_edge && st_q == ST_ADDR) begin
			addr_q <= addr_nx;
		end else if (enter_rd || ostart) begin
			addr_q <= rd_nx;
		end
	end

	// Dummy clock counter
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dcnt_q <= 4'h0;
		end else if (st_q != ST_DUMMY) begin
			dcnt_q <= 4'h0;
		end else if (sck_r) begin
			dcnt_q <= dcnt_q + 4'h1;
		end
	end

	// Array fetch: one byte ahead of the shifter
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_req  <= 1'h0;
			o_rd_addr <= 24'h000000;
		end else begin
			o_rd_req  <= enter_rd | ostart;
			o_rd_addr <= (enter_rd | ostart) ? rd_nx : o_rd_addr;
		end
	end

	// Output shifter and pin drive; released as soon as chip select rises
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			osh_q   <= 8'h00;
			obcnt_q <= 3'h0;
			o_io    <= 4'h0;
			o_io_oe <= 4'h0;
		end else if (!sel || st_q != ST_RDATA) begin
			obcnt_q <= 3'h0;
			o_io    <= 4'h0;
			o_io_oe <= 4'h0;
		end else begin
			o_io_oe <= qpi_q ? OE_QUAD : OE_SINGLE;
			if (out_edge) begin
				obcnt_q <= obcnt_q + ostep;
				o_io    <= qpi_q ? obyte[7:4] : {2'h0, obyte[7], 1'h0};
				osh_q   <= qpi_q ? {obyte[3:0], 4'h0} : {obyte[6:0], 1'h0};
			end
		end
	end

	// Page program: offset wraps inside the page
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			page_q       <= 16'h0000;
			poff_q       <= 8'h00;
			o_prog_valid <= 1'h0;
			o_prog_addr  <= 24'h000000;
			o_prog_data  <= 8'h00;
		end else begin
			o_prog_valid <= wr_done & (op_q == OP_PROG);
			if (addr_done && op_q == OP_PROG) begin
				page_q <= addr_nx[23:8];
				poff_q <= addr_nx[7:0];
			end else if (wr_done && op_q == OP_PROG) begin
				o_prog_addr <= {page_q, poff_q};
				o_prog_data <= sh_nx;
				poff_q      <= poff_q + 8'h01;
			end
		end
	end

	// Sector and block erase are armed by a full address, chip erase by its opcode; all fire at chip select rise
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			er_pend_q     <= 1'h0;
			er_kind_q     <= ER_SECTOR;
			er_addr_q     <= 24'h000000;
			o_erase_valid <= 1'h0;
			o_erase_kind  <= ER_SECTOR;
			o_erase_addr  <= 24'h000000;
		end else begin
			o_erase_valid <= cs_rise & er_pend_q;
			if (cs_rise) begin
				er_pend_q    <= 1'h0;
				o_erase_kind <= er_kind_q;
				o_erase_addr <= er_addr_q;
			end else if (cmd_done) begin
				er_pend_q <= op_chip;
				er_kind_q <= ER_CHIP;
				er_addr_q <= 24'h000000;
			end else if (addr_done && !is_read_q && op_q != OP_PROG) begin
				er_pend_q <= 1'h1;
				er_kind_q <= op_q == OP_BER64 ? ER_BLK64 : (op_q == OP_BER32 ? ER_BLK32 : ER_SECTOR);
				er_addr_q <= addr_nx & ~er_mask;
			end
		end
	end

	// Read settings; a drive code past the sixth setting is refused
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bl_q   <= RP_BL_RST;
			wrap_q <= RP_WRAP_RST;
			drv_q  <= RP_DRV_RST;
		end else if (sw_rst) begin
			bl_q   <= RP_BL_RST;
			wrap_q <= RP_WRAP_RST;
			drv_q  <= RP_DRV_RST;
		end else if (wr_done && op_q == OP_SET_RDPAR) begin
			bl_q   <= sh_nx[RP_BL_LSB +: 2];
			wrap_q <= sh_nx[RP_WRAP_BIT];
			if (sh_nx[RP_DRV_LSB +: 3] < DRV_COUNT) begin
				drv_q <= sh_nx[RP_DRV_LSB +: 3];
			end
		end
	end

	// Status flops; write protect is a data line once quad is enabled
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wp_protect <= 1'h0;
			o_cmd_valid  <= 1'h0;
			o_cmd        <= 8'h00;
		end else begin
			o_wp_protect <= ~io_lvl[2] & ~i_quad_enable & ~qpi_q;
			o_cmd_valid  <= cmd_done;
			o_cmd        <= cmd_done ? sh_nx : o_cmd;
		end
	end

	assign o_quad_mode = qpi_q;
	assign o_burst_len = bl_q;
	assign o_wrap_en   = wrap_q;
	assign o_drive_str = drv_q;

	// Checks
	property p_enter_quad;
		@(posedge i_ref_clk) disable iff (!i_rst_n) cmd_done && sh_nx == OP_ENTER_QUAD |=> o_quad_mode;
	endproperty
	a_enter_quad: assert property (p_enter_quad) else $error("quad mode not entered");

	property p_exit_quad;
		@(posedge i_ref_clk) disable iff (!i_rst_n) cmd_done && (sh_nx == OP_EXIT_QUAD || sw_rst) |=> !o_quad_mode;
	endproperty
	a_exit_quad: assert property (p_exit_quad) else $error("quad mode not left");

	property p_release;
		@(posedge i_ref_clk) disable iff (!i_rst_n) !sel |=> o_io_oe == 4'h0;
	endproperty
	a_release: assert property (p_release) else $error("pins driven while deselected");

	property p_lanes;
		@(posedge i_ref_clk) disable iff (!i_rst_n) o_io_oe != 4'h0 |-> o_io_oe == (qpi_q ? OE_QUAD : OE_SINGLE);
	endproperty
	a_lanes: assert property (p_lanes) else $error("wrong data lanes driven");

	property p_out_edge;
		@(posedge i_ref_clk) disable iff (!i_rst_n) sel && $past(sel) && $changed(o_io) |-> $past(out_edge);
	endproperty
	a_out_edge: assert property (p_out_edge) else $error("output moved off its clock edge");

	property p_ddr_dummy;
		@(posedge i_ref_clk) disable iff (!i_rst_n) cmd_done && sh_nx == OP_FREAD_DTR |=> dneed_q == DUMMY_DDR && dtr_q;
	endproperty
	a_ddr_dummy: assert property (p_ddr_dummy) else $error("DTR dummy count wrong");

	property p_page;
		@(posedge i_ref_clk) disable iff (!i_rst_n) o_prog_valid |-> o_prog_addr[23:8] == page_q;
	endproperty
	a_page: assert property (p_page) else $error("program left its page");

	property p_erase_align;
		@(posedge i_ref_clk) disable iff (!i_rst_n) o_erase_valid && o_erase_kind == ER_BLK32 |-> o_erase_addr[14:0] == 15'h0000;
	endproperty
	a_erase_align: assert property (p_erase_align) else $error("erase address unaligned");

	property p_drive;
		@(posedge i_ref_clk) disable iff (!i_rst_n) o_drive_str < DRV_COUNT;
	endproperty
	a_drive: assert property (p_drive) else $error("drive setting out of range");

	property p_armed;
		@(posedge i_ref_clk) disable iff (!i_rst_n) st_q != ST_IDLE |-> armed_q;
	endproperty
	a_armed: assert property (p_armed) else $error("frame before chip select high");

endmodule

//--- sfx_host_model.sv
// Host-side serial flash controller model that drives the flash pins
`timescale 1ns/1ps
module sfx_host_model (
	// Clock
	input  wire logic       i_ref_clk,
	// Device drive and write-protect idle level
	input  wire logic [3:0] i_dev_io,
	input  wire logic [3:0] i_dev_oe,
	input  wire logic       i_wp_lvl,
	// Pins as the device sees them
	output logic            o_cs_n,
	output logic            o_sck,
	output logic [3:0]      o_io
);
	logic [3:0] dat;
	logic [3:0] hoe;
	logic       tog;
	bit         qd;
	bit         m3;

	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		dat = 4'h0;
		hoe = 4'hC;
		tog = 1'b0;
	end

	// Released lines wander every cycle so a stale bit never reads as good data
	always @(posedge i_ref_clk) tog <= ~tog;

	// Single mode keeps hold high and write-protect at its level; quad drives all four
	always_comb begin
		o_io = qd ? dat : {1'b1, i_wp_lvl, 1'b0, dat[0]};
		for (int k = 0; k < 4; k++) begin
			if (!hoe[k]) o_io[k] = i_dev_oe[k] ? i_dev_io[k] : tog;
		end
	end

	// One serial clock, 4 reference cycles per half; samples 2 cycles after each edge
	task automatic clk(input logic [3:0] a, input logic [3:0] b, input bit ddr,
			output logic [3:0] f, output logic [3:0] r);
		o_sck <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		f = o_io;
		dat <= a;
		repeat (2) @(posedge i_ref_clk);
		o_sck <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		r = o_io;
		if (ddr) dat <= b;
		repeat (2) @(posedge i_ref_clk);
	endtask

	// Frame open: idle level picks clock mode 0 or 3
	task automatic start(input bit mode3, input bit quad);
		m3 = mode3;
		qd <= quad;
		o_sck <= mode3;
		hoe <= quad ? 4'hF : 4'hD;
		repeat (4) @(posedge i_ref_clk);
		o_cs_n <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
	endtask

	task automatic stop();
		if (!m3) o_sck <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		o_cs_n <= 1'b1;
		hoe <= 4'hC;
		repeat (8) @(posedge i_ref_clk);
	endtask

	// MSB first; quad frames move a nibble per clock, bit 3 on line 3
	task automatic shift(input logic [31:0] v, input int nb);
		logic [3:0] f, r;
		for (int i = nb - 1; i >= 0; i -= (qd ? 4 : 1)) begin
			clk(qd ? v[i -: 4] : {3'b000, v[i]}, 4'h0, 1'b0, f, r);
		end
	endtask

	// Double-rate address: one bit before each rise and one before each fall
	task automatic ddr_addr(input logic [23:0] a);
		logic [3:0] f, r;
		for (int i = 23; i > 0; i -= 2) begin
			clk({3'b000, a[i]}, {3'b000, a[i-1]}, 1'b1, f, r);
		end
	endtask

	// Idle clocks collecting line 1 after each fall and each rise
	task automatic run(input int n, output logic [31:0] sf, output logic [31:0] sr);
		logic [3:0] f, r;
		sf = '0;
		sr = '0;
		if (qd) hoe <= 4'h0;
		for (int i = 0; i < n; i++) begin
			clk(4'h0, 4'h0, 1'b0, f, r);
			sf = {sf[30:0], f[1]};
			sr = {sr[30:0], r[1]};
		end
	endtask
endmodule

//--- sfx_front_end_tb.sv
// Self-checking bench for the serial flash front end
`timescale 1ns/1ps
module sfx_front_end_tb;
	import sfx_pkg::*;

	logic        i_ref_clk, i_rst_n, quad_en, wp_lvl, cs_n, sck;
	logic        o_wp_protect, o_quad_mode, o_cmd_valid, o_rd_req, o_prog_valid, o_erase_valid, o_wrap_en;
	logic [3:0]  io, o_io, o_io_oe;
	logic [7:0]  o_cmd, rd_data, last_cmd, o_prog_data;
	logic [23:0] o_rd_addr, o_prog_addr, o_erase_addr;
	logic [1:0]  o_erase_kind, o_burst_len;
	logic [2:0]  o_drive_str;
	logic [31:0] evq[$];
	logic [23:0] rq[$];
	int          n_errors, compares;

	sfx_front_end sfx_front_end_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_sck(sck),
		.i_io(io), .o_io(o_io), .o_io_oe(o_io_oe), .i_quad_enable(quad_en), .o_wp_protect(o_wp_protect),
		.o_quad_mode(o_quad_mode), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_rd_req(o_rd_req),
		.o_rd_addr(o_rd_addr), .i_rd_data(rd_data), .o_prog_valid(o_prog_valid), .o_prog_addr(o_prog_addr),
		.o_prog_data(o_prog_data), .o_erase_valid(o_erase_valid), .o_erase_kind(o_erase_kind),
		.o_erase_addr(o_erase_addr), .o_burst_len(o_burst_len), .o_wrap_en(o_wrap_en), .o_drive_str(o_drive_str));
	sfx_host_model host_i (.i_ref_clk(i_ref_clk), .i_dev_io(o_io), .i_dev_oe(o_io_oe), .i_wp_lvl(wp_lvl),
		.o_cs_n(cs_n), .o_sck(sck), .o_io(io));

	always #12.5 i_ref_clk = ~i_ref_clk;

	function automatic logic [7:0] mem(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction

	// Array side answers a fetch one cycle later and logs writes and erases
	always @(posedge i_ref_clk) begin
		if (o_rd_req) rd_data <= mem(o_rd_addr);
		if (o_rd_req) rq.push_back(o_rd_addr);
		if (o_cmd_valid) last_cmd <= o_cmd;
		if (o_prog_valid) evq.push_back({o_prog_addr, o_prog_data});
		if (o_erase_valid) evq.push_back({6'h00, o_erase_kind, o_erase_addr});
	end

	task automatic summarize();
		$display("compares %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Next logged array event, with a bounded wait
	task automatic get_ev(output logic [31:0] ev);
		for (int k = 0; k < 40 && evq.size() == 0; k++) @(posedge i_ref_clk);
		if (evq.size() == 0) begin
			n_errors++;
			$display("mismatch at %0t: array event missing", $time);
			summarize();
		end else begin
			ev = evq.pop_front();
		end
	endtask

	task automatic frame(input bit quad, input logic [31:0] v, input int nb);
		host_i.start(1'b0, quad);
		host_i.shift(v, nb);
		host_i.stop();
	endtask

	task automatic t_read(input bit mode3);
		logic [31:0] f, r;
		rq.delete();
		host_i.start(mode3, 1'b0);
		host_i.shift({OP_READ, 24'h00A1FF}, 32);
		host_i.run(16, f, r);
		chk(o_io_oe, 4'h2, "single read drive");
		host_i.stop();
		chk(last_cmd, OP_READ, "read opcode");
		chk(rq[0], 24'h00A1FF, "read address");
		chk(r[15:0], {mem(24'h00A1FF), mem(24'h00A200)}, "single read data");
		chk(o_io_oe, 4'h0, "pins released");
	endtask

	task automatic t_quad();
		logic [31:0] ev, f, r;
		host_i.shift(OP_ENTER_QUAD, 8);
		chk(o_quad_mode, 1'b0, "clocks while deselected");
		wp_lvl <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
		chk(o_wp_protect, 1'b1, "write protect held");
		quad_en <= 1'b1;
		repeat (8) @(posedge i_ref_clk);
		chk(o_wp_protect, 1'b0, "quad enable frees pin");
		quad_en <= 1'b0;
		frame(1'b0, OP_ENTER_QUAD, 8);
		chk({o_quad_mode, o_wp_protect}, 2'b10, "quad mode entry");
		frame(1'b1, {OP_SER_B, 24'h123456}, 32);
		get_ev(ev);
		chk(ev, {6'h00, ER_SECTOR, 24'h123000}, "quad sector erase");
		host_i.start(1'b0, 1'b1);
		host_i.shift({OP_READ, 24'h000010}, 32);
		host_i.run(1, f, r);
		chk(io, mem(24'h000010) >> 4, "quad read high nibble");
		chk(o_io_oe, OE_QUAD, "quad read lanes");
		host_i.run(1, f, r);
		chk(io, mem(24'h000010) & 8'h0F, "quad read low nibble");
		host_i.stop();
		frame(1'b1, OP_EXIT_QUAD, 8);
		chk(o_quad_mode, 1'b0, "quad mode exit");
		wp_lvl <= 1'b1;
	endtask

	task automatic t_erase();
		logic [7:0]  ops [6] = '{OP_SER_A, OP_SER_B, OP_BER32, OP_BER64, OP_CER_A, OP_CER_B};
		sfx_erase_t  kinds [6] = '{ER_SECTOR, ER_SECTOR, ER_BLK32, ER_BLK64, ER_CHIP, ER_CHIP};
		logic [23:0] masks [4] = '{MASK_4K, MASK_4K, MASK_32K, MASK_64K};
		logic [31:0] ev;
		for (int i = 0; i < 6; i++) begin
			frame(1'b0, (i < 4) ? {ops[i], 24'h3ABCDE} : {24'h0, ops[i]}, (i < 4) ? 32 : 8);
			get_ev(ev);
			chk(ev[25:24], kinds[i], "erase kind");
			if (i < 4) chk(ev[23:0], 24'h3ABCDE & ~masks[i], "erase alignment");
		end
	endtask

	// Program starting two bytes before a page end; the third byte wraps in the page
	task automatic t_prog();
		logic [31:0] ev;
		host_i.start(1'b0, 1'b0);
		host_i.shift({OP_PROG, 24'h0045FE}, 32);
		for (int i = 0; i < 3; i++) host_i.shift(8'(8'h11 * (i + 1)), 8);
		host_i.stop();
		for (int i = 0; i < 3; i++) begin
			get_ev(ev);
			chk(ev, {16'h0045, 8'hFE + 8'(i), 8'(8'h11 * (i + 1))}, "page program");
		end
	endtask

	// Codes 0..5 take effect; drive code 6 is refused and 5 stays
	task automatic t_params();
		for (int i = 0; i < 7; i++) begin
			frame(1'b0, {OP_SET_RDPAR, 3'(i), 2'b00, i[0], i[1:0]}, 16);
			chk({o_burst_len, o_wrap_en, o_drive_str}, {i[1:0], i[0], (i < 6) ? 3'(i) : 3'h5}, "read settings");
		end
		frame(1'b0, {OP_SET_RDPAR, 8'h00}, 16);
	endtask

	// Double-rate read in mode 3: half the dummy clocks, data on both edges
	task automatic t_ddr();
		logic [31:0] f, r;
		rq.delete();
		host_i.start(1'b1, 1'b0);
		host_i.shift(OP_FREAD_DTR, 8);
		host_i.ddr_addr(24'h00C35A);
		host_i.run(9, f, r);
		host_i.stop();
		chk(rq[0], 24'h00C35A, "double-rate address");
		chk({r[4], f[3], r[3], f[2], r[2], f[1], r[1], f[0]}, mem(24'h00C35A), "double-rate data");
	endtask

	task automatic t_resets();
		frame(1'b0, OP_ENTER_QUAD, 8);
		frame(1'b1, {OP_SET_RDPAR, 8'hA7}, 16);
		chk({o_quad_mode, o_burst_len, o_wrap_en, o_drive_str}, 7'h7D, "settings before reset");
		frame(1'b1, OP_RST_EN, 8);
		frame(1'b1, OP_RST, 8);
		chk({o_quad_mode, o_burst_len, o_wrap_en, o_drive_str}, 7'h00, "software reset");
		frame(1'b0, OP_ENTER_QUAD, 8);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (10) @(posedge i_ref_clk);
		chk(o_quad_mode, 1'b0, "hardware reset");
	endtask

	initial begin
		i_ref_clk = 1'b0;
		i_rst_n = 1'b0;
		quad_en = 1'b0;
		wp_lvl = 1'b1;
		rd_data = 8'h00;
		repeat (5) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (10) @(posedge i_ref_clk);
		chk({o_quad_mode, o_io_oe, o_burst_len, o_wrap_en, o_drive_str, o_wp_protect}, 0, "reset state");
		t_read(1'b0);
		t_read(1'b1);
		t_quad();
		t_erase();
		t_prog();
		t_params();
		t_ddr();
		t_resets();
		summarize();
	end

	// A hang ends in the same report
	initial begin
		#1ms;
		n_errors++;
		$display("mismatch at %0t: run timed out", $time);
		summarize();
	end
endmodule
